// [bench/asc_host_model.sv]
// Host model that frames commands and data on the three-wire serial port
`timescale 1ns/1ns
`default_nettype none

module asc_host_model #(
  parameter int HALF = 6                // Cycles per serial clock phase
) (
  // Clock
  input  wire logic sys_clk,
  // Serial port
  input  wire logic dout_rdy_o,
  output logic      sclk_pin,
  output logic      din_pin,
  output logic      cs_n_pin
);
  // --------------------------------------------------------------
  // Idle pins: serial clock parked high, device deselected
  // --------------------------------------------------------------
  initial
  begin
    sclk_pin = 1'b1;
    din_pin  = 1'b1;
    cs_n_pin = 1'b1;
  end

  // Let whole cycles pass, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // One frame: command byte, then n data bits; dropped after cut bits
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd,
                      input int n, input int cut, output logic [15:0] rd);
    logic [23:0] sh;
    sh = {cmd, wd << (16 - n)};
    rd = 16'h0000;
    tick(1);
    cs_n_pin = 1'b0;
    tick(HALF);
    for (int i = 0; i < 8 + n; i++)
    begin
      // Abort mid-frame when asked, leaving a partial unit behind
      if (i == cut)
        break;
      sclk_pin = 1'b0;
      din_pin  = sh[23 - i];
      tick(HALF);
      // Host reads the bit at its own rising edge
      rd       = {rd[14:0], dout_rdy_o};
      sclk_pin = 1'b1;
      tick(HALF);
    end
    // A released data line must not keep showing the last bit
    din_pin  = ~din_pin;
    cs_n_pin = 1'b1;
    tick(HALF);
  endtask
endmodule
`default_nettype wire

// [bench/asc_regs_bench.sv]
// Self-checking bench for the status and mode register bank
`timescale 1ns/1ns
`default_nettype none

module asc_regs_bench;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic                  sys_clk = 1'b0;
  logic                  reset   = 1'b1;
  logic                  sclk_pin, din_pin, cs_n_pin;
  logic                  dout_rdy_o, dout_rdy_oe;
  logic                  clk_pin_i = 1'b0;  // Slow external clock
  logic                  clk_pin_o, clk_pin_oe;
  logic                  res24_strap = 1'b1; // 24-bit variant strap
  asc_pkg::asc_conv_evt_s conv_evt = '0;
  logic [2:0]            active_channel_code = 3'h0;
  asc_pkg::asc_setup_s   setup_o;
  logic                  filter_reset_o, adc_clk_tick_o;
  int                    errors = 0;
  int                    total_checks = 0;
  int                    ticks = 0;         // Converter clock pulses
  int                    fresets = 0;       // Filter reset pulses
  int                    ext_cnt = 0;

  always #25 sys_clk = ~sys_clk;

  // --------------------------------------------------------------
  // Instances
  // --------------------------------------------------------------
  asc_regs DUT (.sys_clk(sys_clk), .reset(reset), .sclk_pin(sclk_pin),
    .din_pin(din_pin), .cs_n_pin(cs_n_pin), .dout_rdy_o(dout_rdy_o),
    .dout_rdy_oe(dout_rdy_oe), .clk_pin_i(clk_pin_i),
    .clk_pin_o(clk_pin_o), .clk_pin_oe(clk_pin_oe),
    .res24_strap(res24_strap), .conv_evt(conv_evt),
    .active_channel_code(active_channel_code), .setup_o(setup_o),
    .filter_reset_o(filter_reset_o), .adc_clk_tick_o(adc_clk_tick_o));

  asc_host_model host (.sys_clk(sys_clk), .dout_rdy_o(dout_rdy_o),
    .sclk_pin(sclk_pin), .din_pin(din_pin), .cs_n_pin(cs_n_pin));

  // Pulse counters and an external clock of 80 cycles per period
  always @(posedge sys_clk)
  begin
    if (adc_clk_tick_o === 1'b1)
      ticks++;
    if (filter_reset_o === 1'b1)
      fresets++;
    ext_cnt = (ext_cnt == 39) ? 0 : ext_cnt + 1;
    if (ext_cnt == 0)
      clk_pin_i <= #1 ~clk_pin_i;
  end

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic check(input logic [15:0] got, exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Counts are bench integers, so a window is enough
  task automatic check_rng(input int got, lo, hi, input string what);
    total_checks++;
    if (got < lo || got > hi)
    begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, lo);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One-cycle event pulse from the conversion core
  task automatic evt(input logic [4:0] v);
    conv_evt = v;
    host.tick(1);
    conv_evt = '0;
    host.tick(2);
  endtask

  task automatic rd_status(output logic [7:0] s);
    logic [15:0] r;
    host.xfer(8'h40, 16'h0000, 8, 99, r);
    s = r[7:0];
  endtask

  task automatic wr_mode(input logic [15:0] v);
    logic [15:0] r;
    host.xfer(8'h08, v, 16, 99, r);
  endtask

  // Bounded wait for a clock pin level; a hang ends the run
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (clk_pin_o !== v)
    begin
      host.tick(1);
      n++;
      if (n > 400)
      begin
        check(16'h0000, 16'h0001, "clock pin stuck");
        wrap_up();
      end
    end
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    logic [7:0]  s;
    logic [15:0] r;
    check(dout_rdy_o, 1'b1, "ready pin");
    check(dout_rdy_oe, 1'b0, "pin released");
    check(clk_pin_oe, 1'b0, "clock pin idle");
    rd_status(s);
    check(s, 8'h88, "status reset");
    check(setup_o, 16'h000a, "setup reset");
    host.xfer(8'h48, 16'h0000, 16, 99, r);
    check(r, 16'h000a, "mode read");
    $display("test reset done");
  endtask

  task automatic t_events();
    logic [7:0] s;
    logic [4:0] setter [3] = '{5'b00100, 5'b00010, 5'b00001};
    active_channel_code = 3'h5;
    evt(5'b11000);
    check(dout_rdy_o, 1'b0, "ready pin low");
    rd_status(s);
    check(s, 8'h4d, "clamped result");
    for (int k = 0; k < 3; k++)
    begin
      evt(setter[k]);
      rd_status(s);
      check(s, (k == 0) ? 8'hcd : 8'h8d, "ready set");
      evt(5'b10000);
      rd_status(s);
      check(s, 8'h0d, "new result");
    end
    $display("test events done");
  endtask

  task automatic t_mode_write();
    logic [7:0]  s;
    logic [15:0] r;
    evt(5'b11000);
    fresets = 0;
    wr_mode(16'h2083);
    check(fresets, 1, "filter reset");
    check(setup_o, 16'h2083, "setup fields");
    rd_status(s);
    check(s, 8'h8d, "status after write");
    host.xfer(8'h48, 16'h0000, 16, 99, r);
    check(r, 16'h2083, "mode readback");
    $display("test mode write done");
  endtask

  task automatic t_refused();
    logic [7:0]  s;
    logic [15:0] r;
    host.xfer(8'h00, 16'h0000, 0, 99, r);
    rd_status(s);
    check(s, 8'h8d, "status write");
    host.xfer(8'h08, 16'hffff, 16, 14, r);
    check(setup_o, 16'h2083, "aborted write");
    check(fresets, 1, "no filter reset");
    $display("test refused done");
  endtask

  task automatic t_clocks();
    int n;
    wr_mode(16'h004a);
    check(clk_pin_oe, 1'b1, "clock pin driven");
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, n);
    check_rng(n, 156, 156, "half period");
    ticks = 0;
    host.tick(1560);
    check_rng(ticks, 5, 5, "internal ticks");
    wr_mode(16'h604a);
    ticks = 0;
    host.tick(400);
    check(clk_pin_oe, 1'b0, "pin off in sleep");
    check_rng(ticks, 0, 0, "ticks in sleep");
    wr_mode(16'h008a);
    ticks = 0;
    host.tick(1600);
    check_rng(ticks, 19, 21, "external ticks");
    wr_mode(16'h00ca);
    ticks = 0;
    host.tick(1600);
    check_rng(ticks, 9, 11, "halved ticks");
    $display("test clocks done");
  endtask

  // Second reset in mid-run with the 16-bit strap: defaults return
  task automatic t_rerun();
    logic [7:0] s;
    active_channel_code = 3'h0;
    res24_strap = 1'b0;
    reset = 1'b1;
    host.tick(2);
    reset = 1'b0;
    host.tick(4);
    check(dout_rdy_o, 1'b1, "ready pin again");
    check(dout_rdy_oe, 1'b0, "pin released");
    check(setup_o, 16'h000a, "setup again");
    check(clk_pin_oe, 1'b0, "clock pin idle");
    rd_status(s);
    check(s, 8'h80, "16-bit status");
    $display("test rerun done");
  endtask

  // --------------------------------------------------------------
  // Main sequence: reset for 12 cycles, then the scenarios
  // --------------------------------------------------------------
  initial
  begin
    host.tick(12);
    reset = 1'b0;
    host.tick(4);
    t_reset();
    t_events();
    t_mode_write();
    t_refused();
    t_clocks();
    t_rerun();
    wrap_up();
  end
endmodule
`default_nettype wire

// [pkg/asc_pkg.sv]
// Types shared by the status and mode register bank
package asc_pkg;

  // Converter operating modes
  typedef enum logic [2:0] {
    ASC_MD_CONT      = 3'h0,
    ASC_MD_SINGLE    = 3'h1,
    ASC_MD_IDLE      = 3'h2,
    ASC_MD_PDOWN     = 3'h3,
    ASC_MD_INT_ZERO  = 3'h4,
    ASC_MD_RESERVED  = 3'h5,
    ASC_MD_SYS_ZERO  = 3'h6,
    ASC_MD_SYS_FULL  = 3'h7
  } asc_mode_e;

  // Converter clock sources
  typedef enum logic [1:0] {
    ASC_CK_INT       = 2'h0,
    ASC_CK_INT_OUT   = 2'h1,
    ASC_CK_EXT       = 2'h2,
    ASC_CK_EXT_DIV2  = 2'h3
  } asc_clk_src_e;

  // Serial engine states, one-hot
  typedef enum logic [3:0] {
    ASC_S_CMD  = 4'h1,
    ASC_S_RD   = 4'h2,
    ASC_S_WR   = 4'h4,
    ASC_S_SKIP = 4'h8
  } asc_state_e;

  // Mode register layout
  typedef struct packed {
    asc_mode_e    operating_mode_select;
    logic [4:0]   zero_hi;
    asc_clk_src_e clock_source_select;
    logic [1:0]   zero_lo;
    logic [3:0]   update_rate_select;
  } asc_setup_s;

  // Events from the conversion core
  typedef struct packed {
    logic data_written;
    logic clamped;
    logic pre_update;
    logic data_read;
    logic enter_pdown;
  } asc_conv_evt_s;

endpackage

// [pkg/asc_regs.svh]
// Register selects, field positions, reset values and timing of the bank
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH

// Register select codes carried in the command byte
`define ASC_SEL_STATUS      3'h0
`define ASC_SEL_SETUP       3'h1

// Reset values
`define ASC_STATUS_RESET    8'h80
`define ASC_SETUP_RESET     16'h000a

// Register sizes in bits
`define ASC_STATUS_BITS     5'h08
`define ASC_SETUP_BITS      5'h10
`define ASC_OTHER_BITS      5'h08

// Status field positions
`define ASC_ST_READY_BIT    7
`define ASC_ST_ERR_BIT      6
`define ASC_ST_VARIANT_BIT  3

// Command byte field positions (write-enable bit not stored)
`define ASC_CMD_RW_BIT      6
`define ASC_CMD_SEL_HI      5
`define ASC_CMD_SEL_LO      3

// Timing: system clock and internal oscillator rates in hertz
`define ASC_SYS_CLK_HZ      20000000
`define ASC_OSC_HZ          64000

`endif

// [rtl/asc_pin_sync.sv]
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none

module asc_pin_sync #(
  parameter int           W    = 5,
  parameter logic [W-1:0] INIT = '0   // Idle level of each pin
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         reset,
  // Pins and synchronised levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);

  logic [W-1:0] meta_reg;  // First stage, read only by the second

  // ----------------------------------------------------------------
  // Two flops per pin
  // ----------------------------------------------------------------
  // Only the second stage leaves this module, so nothing can see a
  // metastable level
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      // Idle levels, so that no false edge follows reset
      meta_reg <= INIT;
      pin_sync <= INIT;
    end
    else
    begin
      meta_reg <= pin_in;
      pin_sync <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// [rtl/asc_regs.sv]
// Status and mode register bank behind the three-wire serial port
//
// Function
// - Read-only 8-bit status, resets to 80h
// - Status shifts out bit 7 first
// - New result clears the ready flag
// - Data read or pending update sets ready
// - Entering power-down sets the ready flag
// - Data-out pin also shows ready level
// - Clamp flag updates with ready flag
// - Conversion-starting write clears clamp flag
// - Status bits 5 and 4 read zero
// - Bit 3 shows the resolution variant
// - Bits 2..0 show active channel
// - 16-bit read/write mode, resets to 000Ah
// - Mode register shifts bit 15 first
// - Mode write resets filter, sets ready
// - Bits 15..13 select operating mode
// - Codes 00/01 internal oscillator, 01 drives pin
// - Code 10 external clock, 11 halves it
// - Bits 3..0 select update rate
// - Operating mode code meanings
// - Select 000 status/command, 001 mode
`timescale 1ns/1ns
`default_nettype none
`include "asc_regs.svh"

module asc_regs (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  // Serial port pins
  input  wire logic                   sclk_pin,
  input  wire logic                   din_pin,
  input  wire logic                   cs_n_pin,
  output logic                        dout_rdy_o,
  output logic                        dout_rdy_oe,
  // Converter clock pin
  input  wire logic                   clk_pin_i,
  output logic                        clk_pin_o,
  output logic                        clk_pin_oe,
  // Resolution strap, high on the 24-bit variant
  input  wire logic                   res24_strap,
  // Conversion core side
  input  wire asc_pkg::asc_conv_evt_s conv_evt,
  input  wire logic [2:0]             active_channel_code,
  output asc_pkg::asc_setup_s         setup_o,
  output logic                        filter_reset_o,
  output logic                        adc_clk_tick_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int OSC_HALF = `ASC_SYS_CLK_HZ / (2 * `ASC_OSC_HZ);
  localparam logic [7:0] STATUS_RST = `ASC_STATUS_RESET;  // Reset image

  logic [4:0]           sync_vec;      // Synchronised pins
  logic                 sclk_s;        // Serial clock level
  logic                 din_s;         // Serial data level
  logic                 cs_act;        // Chip select asserted
  logic                 clk_s;         // External clock level
  logic                 strap_s;       // Strap level
  logic                 sclk_d;        // Previous serial clock
  logic                 clk_d;         // Previous external clock
  logic                 sclk_rise;     // Sample edge
  logic                 sclk_fall;     // Shift edge
  logic                 clk_rise;      // External clock edge

  asc_pkg::asc_state_e  state_reg;     // Serial engine state
  logic [4:0]           cnt_reg;       // Bit counter
  logic [4:0]           len_reg;       // Data phase length
  logic [5:0]           cmd_reg;       // Command bits so far
  logic [15:0]          out_reg;       // Read shifter
  logic [14:0]          in_reg;        // Write shifter
  logic [6:0]           cmd_byte;      // Command after its last bit
  logic                 mode_wr_reg;   // Mode write pulse
  logic [15:0]          wr_data_reg;   // Mode write value

  asc_pkg::asc_setup_s  setup_reg;     // Mode register
  logic                 rdy_reg;       // Ready flag, high = no data
  logic                 err_reg;       // Clamp flag
  logic [2:0]           chan_reg;      // Active channel
  logic                 variant_reg;   // Resolution variant
  logic                 strap_done;    // Strap caught
  logic [1:0]           strap_age;     // Cycles since reset release
  logic                 rdy_set;       // Any ready set source
  logic                 start_wr;      // Write that starts a conversion

  logic [8:0]           osc_cnt;       // Oscillator divider
  logic                 osc_phase;     // Oscillator square wave
  logic                 ext_div;       // Divide-by-two phase

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Status byte assembled from the live flags
  function automatic logic [7:0] status_word(input logic rdy,
                                             input logic err,
                                             input logic var24,
                                             input logic [2:0] ch);
    status_word = {rdy, err, 2'b00, var24, ch};
  endfunction

  // Mode codes after which a conversion is running
  function automatic logic starts_conv(input asc_pkg::asc_mode_e md);
    starts_conv = (md == asc_pkg::ASC_MD_CONT) ||
                  (md == asc_pkg::ASC_MD_SINGLE);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------------------------------
  asc_pin_sync #(
    .W        (5),
    // Serial clock parked high and chip select released at reset
    .INIT     (5'b00101)
  ) u_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .pin_in   ({res24_strap, clk_pin_i, cs_n_pin, din_pin, sclk_pin}),
    .pin_sync (sync_vec)
  );

  assign sclk_s    = sync_vec[0];
  assign din_s     = sync_vec[1];
  assign cs_act    = ~sync_vec[2];
  assign clk_s     = sync_vec[3];
  assign strap_s   = sync_vec[4];
  assign sclk_rise = sclk_s & ~sclk_d;
  assign sclk_fall = ~sclk_s & sclk_d;
  assign clk_rise  = clk_s & ~clk_d;
  assign cmd_byte  = {cmd_reg, din_s};

  // Edge history
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      sclk_d <= 1'b1;
      clk_d  <= 1'b0;
    end
    else
    begin
      sclk_d <= sclk_s;
      clk_d  <= clk_s;
    end
  end

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  // Releasing chip select aborts any frame and waits for a command
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg   <= asc_pkg::ASC_S_CMD;
      cnt_reg     <= 5'h00;
      len_reg     <= 5'h00;
      cmd_reg     <= 6'h00;
      out_reg     <= 16'h0000;
      in_reg      <= 15'h0000;
      mode_wr_reg <= 1'b0;
      wr_data_reg <= 16'h0000;
    end
    else
    begin
      mode_wr_reg <= 1'b0;
      if (!cs_act)
      begin
        state_reg <= asc_pkg::ASC_S_CMD;
        cnt_reg   <= 5'h00;
      end
      else
      begin
        unique case (state_reg)
          asc_pkg::ASC_S_CMD:
          begin
            if (sclk_rise && cnt_reg == 5'h00)
            begin
              // A leading one is not a write enable: stay put
              if (!din_s)
                cnt_reg <= 5'h01;
            end
            else if (sclk_rise && cnt_reg != 5'h07)
            begin
              cmd_reg <= cmd_byte[5:0];
              cnt_reg <= cnt_reg + 5'h01;
            end
            else if (sclk_rise)
            begin
              cnt_reg <= 5'h00;
              // Read of select zero fetches status
              if (cmd_byte[`ASC_CMD_RW_BIT] &&
                  cmd_byte[`ASC_CMD_SEL_HI:`ASC_CMD_SEL_LO] ==
                  `ASC_SEL_STATUS)
              begin
                out_reg   <= {status_word(rdy_reg, err_reg, variant_reg,
                                          chan_reg), 8'h00};
                len_reg   <= `ASC_STATUS_BITS;
                state_reg <= asc_pkg::ASC_S_RD;
              end
              else if (cmd_byte[`ASC_CMD_SEL_HI:`ASC_CMD_SEL_LO] ==
                       `ASC_SEL_SETUP)
              begin
                out_reg   <= setup_reg;
                len_reg   <= `ASC_SETUP_BITS;
                state_reg <= cmd_byte[`ASC_CMD_RW_BIT] ?
                             asc_pkg::ASC_S_RD : asc_pkg::ASC_S_WR;
              end
              // Write of select zero hits the command register only
              else if (cmd_byte[`ASC_CMD_SEL_HI:`ASC_CMD_SEL_LO] ==
                       `ASC_SEL_STATUS)
                state_reg <= asc_pkg::ASC_S_CMD;
              // Registers kept elsewhere: let their bits pass
              else
              begin
                len_reg   <= `ASC_OTHER_BITS;
                state_reg <= asc_pkg::ASC_S_SKIP;
              end
            end
          end
          asc_pkg::ASC_S_RD:
          begin
            // MSB leaves first, next bit after each falling edge; the
            // fall before the first sampling edge keeps the MSB up
            if (sclk_fall && cnt_reg != 5'h00)
              out_reg <= {out_reg[14:0], 1'b0};
            if (sclk_rise)
            begin
              cnt_reg <= cnt_reg + 5'h01;
              if (cnt_reg == len_reg - 5'h01)
              begin
                cnt_reg   <= 5'h00;
                state_reg <= asc_pkg::ASC_S_CMD;
              end
            end
          end
          asc_pkg::ASC_S_WR:
          begin
            if (sclk_rise)
            begin
              in_reg  <= {in_reg[13:0], din_s};
              cnt_reg <= cnt_reg + 5'h01;
              if (cnt_reg == len_reg - 5'h01)
              begin
                wr_data_reg <= {in_reg, din_s};
                mode_wr_reg <= 1'b1;
                cnt_reg     <= 5'h00;
                state_reg   <= asc_pkg::ASC_S_CMD;
              end
            end
          end
          asc_pkg::ASC_S_SKIP:
          begin
            if (sclk_rise)
            begin
              cnt_reg <= cnt_reg + 5'h01;
              if (cnt_reg == len_reg - 5'h01)
              begin
                cnt_reg   <= 5'h00;
                state_reg <= asc_pkg::ASC_S_CMD;
              end
            end
          end
        endcase
      end
    end
  end

  // Data-out pin: read bits in a read phase, ready level otherwise
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      dout_rdy_o  <= 1'b1;
      dout_rdy_oe <= 1'b0;
    end
    else
    begin
      dout_rdy_o  <= (state_reg == asc_pkg::ASC_S_RD) ? out_reg[15]
                                                       : rdy_reg;
      dout_rdy_oe <= cs_act;
    end
  end

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  // Stored as written; reserved bits are the host's to keep zero
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      setup_reg      <= `ASC_SETUP_RESET;
      filter_reset_o <= 1'b0;
    end
    else
    begin
      filter_reset_o <= mode_wr_reg;
      if (mode_wr_reg)
        setup_reg <= wr_data_reg;
    end
  end

  assign setup_o = setup_reg;

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  assign rdy_set  = conv_evt.data_read | conv_evt.pre_update |
                    conv_evt.enter_pdown | mode_wr_reg;
  assign start_wr = mode_wr_reg &&
                    starts_conv(asc_pkg::asc_mode_e'(wr_data_reg[15:13]));

  // Ready flag: any set wins over a result landing in the same cycle
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      rdy_reg <= STATUS_RST[`ASC_ST_READY_BIT];
    else if (rdy_set)
      rdy_reg <= 1'b1;
    else if (conv_evt.data_written)
      rdy_reg <= 1'b0;
  end

  // Clamp flag follows each result; a fresh start clears it
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      err_reg <= STATUS_RST[`ASC_ST_ERR_BIT];
    else if (conv_evt.data_written)
      err_reg <= conv_evt.clamped;
    else if (start_wr)
      err_reg <= 1'b0;
  end

  // Channel follows the core; strap caught once after release
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      chan_reg    <= 3'h0;
      variant_reg <= 1'b0;
      strap_done  <= 1'b0;
      strap_age   <= 2'h0;
    end
    else
    begin
      chan_reg <= active_channel_code;
      // The strap needs two cycles to clear the synchroniser
      if (strap_age != 2'h2)
        strap_age <= strap_age + 2'h1;
      else if (!strap_done)
      begin
        variant_reg <= strap_s;
        strap_done  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Converter clock
  // ----------------------------------------------------------------
  // Ticks and the clock pin drive stop in power-down; the oscillator divider and clk_pin_o keep running
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      osc_cnt        <= 9'h000;
      osc_phase      <= 1'b0;
      ext_div        <= 1'b0;
      adc_clk_tick_o <= 1'b0;
      clk_pin_o      <= 1'b0;
      clk_pin_oe     <= 1'b0;
    end
    else
    begin
      adc_clk_tick_o <= 1'b0;
      if (osc_cnt == 9'(OSC_HALF - 1))
      begin
        osc_cnt   <= 9'h000;
        osc_phase <= ~osc_phase;
      end
      else
        osc_cnt <= osc_cnt + 9'h001;
      clk_pin_o  <= osc_phase;
      clk_pin_oe <= (setup_reg.clock_source_select ==
                     asc_pkg::ASC_CK_INT_OUT) &&
                    (setup_reg.operating_mode_select !=
                     asc_pkg::ASC_MD_PDOWN);
      if (setup_reg.operating_mode_select != asc_pkg::ASC_MD_PDOWN)
      begin
        unique case (setup_reg.clock_source_select)
          asc_pkg::ASC_CK_INT, asc_pkg::ASC_CK_INT_OUT:
            adc_clk_tick_o <= (osc_cnt == 9'(OSC_HALF - 1)) &&
                              !osc_phase;
          asc_pkg::ASC_CK_EXT:
            adc_clk_tick_o <= clk_rise;
          asc_pkg::ASC_CK_EXT_DIV2:
          begin
            if (clk_rise)
              ext_div <= ~ext_div;
            adc_clk_tick_o <= clk_rise && ext_div;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_wr_sets_ready: assert property (mode_wr_reg |=> rdy_reg)
    else $error("mode write did not set ready");
  a_wr_filter_rst: assert property (mode_wr_reg |=> filter_reset_o)
    else $error("mode write did not reset filter");
  a_result_clears: assert property (
    conv_evt.data_written && !rdy_set |=> !rdy_reg)
    else $error("new result did not clear ready");
  a_read_sets_rdy: assert property (
    conv_evt.data_read || conv_evt.pre_update ||
    conv_evt.enter_pdown |=> rdy_reg)
    else $error("read, update or power-down did not set ready");
  a_err_follows: assert property (
    conv_evt.data_written |=> err_reg == $past(conv_evt.clamped))
    else $error("clamp flag did not follow result");
  a_err_start_clr: assert property (
    start_wr && !conv_evt.data_written |=> !err_reg)
    else $error("starting write did not clear clamp flag");
  a_chan_follows: assert property (
    ##1 chan_reg == $past(active_channel_code))
    else $error("channel code does not follow core");
  a_setup_update: assert property (
    mode_wr_reg |=> setup_reg == $past(wr_data_reg) ##1
    ($stable(setup_reg) || $past(mode_wr_reg)))
    else $error("mode register not loaded");
  a_pdown_clk_off: assert property (
    (setup_reg.operating_mode_select == asc_pkg::ASC_MD_PDOWN) [*2]
    |-> !clk_pin_oe && !adc_clk_tick_o)
    else $error("clock active in power-down");

endmodule
`default_nettype wire
